// >>> asc_pkg.sv
`default_nettype none
package asc_pkg;
    // Register map, byte address on the peripheral bus
    localparam logic [31:0] ASC_CTRL_ADDR = 32'h4000_3058;
    localparam logic [15:0] ASC_CTRL_RESET = 16'h0000;
    // Field positions inside the control register
    localparam int ASC_MST_CTL_LSB = 0;
    localparam int ASC_SLV_CTL_LSB = 4;
    localparam int ASC_MST_FLAG_BIT = 8;
    localparam int ASC_SLV_FLAG_BIT = 9;
    localparam logic [7:0] ASC_CTL_RESET = 8'h00;
    // Stretch setting encodings
    localparam logic [3:0] ASC_MODE_OFF = 4'h0;
    localparam logic [3:0] ASC_MODE_NOLIMIT = 4'hf;
    // Two-byte FIFO levels
    localparam logic [1:0] ASC_FIFO_EMPTY = 2'h0;
    localparam logic [1:0] ASC_FIFO_FULL = 2'h2;
    // Divisor fields feeding the timeout base
    localparam int ASC_DIV_HI_LSB = 8;
    localparam int ASC_DIV_LO_LSB = 4;
    // Widths of the timeout arithmetic: 269 * 2^14 fits in 23 bits
    localparam int ASC_BASE_W = 9;
    localparam int ASC_TMR_W = 23;
    localparam logic [9:0] ASC_BASE_MIN = 10'h001;
    // Clock of this block: the divided system clock
    localparam int ASC_MCLK_PERIOD_NS = 100;
    // AXI4-Lite responses
    localparam logic [1:0] ASC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ASC_RESP_SLVERR = 2'h2;

    // Stretch engine states
    typedef enum logic [1:0] {
        ASC_IDLE = 2'b00,
        ASC_HOLD_TX = 2'b01,
        ASC_HOLD_RX = 2'b10
    } asc_hold_t;
endpackage
`default_nettype wire

// >>> asc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module asc_sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic mclk,
    input wire logic rstN,
    input wire logic d,
    output logic q
);
    logic firstQ;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            firstQ <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            firstQ <= d;
            q <= firstQ;
        end
    end
endmodule // asc_sync2
`default_nettype wire

// >>> asc_stretch_unit.sv
`timescale 1ns/1ps
`default_nettype none
module asc_stretch_unit
    import asc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstSyncN,
    input wire logic [3:0] mode,
    input wire logic sclFall,
    input wire logic txPoint,
    input wire logic rxPoint,
    input wire logic [1:0] txLevel,
    input wire logic [1:0] rxLevel,
    input wire logic [ASC_BASE_W-1:0] baseCount,
    output logic hold,
    output logic holdTx,
    output logic timeout
);
    typedef struct packed {
        asc_hold_t state;
        logic [ASC_TMR_W-1:0] cnt;
        logic timeout;
    } asc_unit_t;

    asc_unit_t q, d;
    logic [ASC_TMR_W-1:0] limit;

    // Timeout length in cycles: base times two to the setting
    assign limit = ASC_TMR_W'(baseCount) << mode;

    // Stretch decision, release and timeout counting
    always_comb begin
        d = q;
        d.timeout = 1'b0;
        unique case (q.state)
            ASC_IDLE: begin
                d.cnt = '0;
                if (mode != ASC_MODE_OFF && sclFall) begin
                    if (txPoint && txLevel == ASC_FIFO_EMPTY) begin
                        d.state = ASC_HOLD_TX;
                    end else if (rxPoint && rxLevel == ASC_FIFO_FULL) begin
                        d.state = ASC_HOLD_RX;
                    end
                end
            end
            ASC_HOLD_TX, ASC_HOLD_RX: begin
                // Data arrival releases before a timeout is counted
                if (mode == ASC_MODE_OFF
                    || (q.state == ASC_HOLD_TX && txLevel != ASC_FIFO_EMPTY)
                    || (q.state == ASC_HOLD_RX && rxLevel != ASC_FIFO_FULL)) begin
                    d.state = ASC_IDLE;
                end else if (mode != ASC_MODE_NOLIMIT
                    && q.cnt == limit - 1'b1) begin
                    d.state = ASC_IDLE;
                    d.timeout = 1'b1;
                end else begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
            default: begin
                d.state = ASC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            q <= '{state: ASC_IDLE, cnt: '0, timeout: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign hold = q.state != ASC_IDLE;
    assign holdTx = q.state == ASC_HOLD_TX;
    assign timeout = q.timeout;
endmodule // asc_stretch_unit
`default_nettype wire

// >>> asc_auto_stretch.sv
// What this block does
// - Slave timeout sets flag; read clears it
// - Master timeout sets flag; read clears it
// - Slave stretch setting in bits 7:4
// - Slave transmit: hold SCL while FIFO empty
// - Slave transmit release on data or timeout
// - Slave receive: hold SCL while FIFO full
// - Slave receive release when not full, timeout
// - Slave setting zero: never stretch
// - Slave settings 1-14: timed by divisor formula
// - Slave timeout ignores actual bus bit rate
// - Slave setting all ones: stretch without timeout
// - Master stretch setting in bits 3:0
// - Master transmit: hold SCL while FIFO empty
// - Master transmit release on data or timeout
// - Master receive: hold SCL while FIFO full
// - Master receive release when not full, timeout
// - Master setting zero: never stretch
// - Master settings 1-14: timed by divisor formula
// - Master setting all ones: no timeout
// - FIFOs hold two bytes; full two, empty zero
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module asc_auto_stretch
    import asc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic [15:0] serialClockDivisor,
    input wire logic slvTxPoint,
    input wire logic slvRxPoint,
    input wire logic mstTxPoint,
    input wire logic mstRxPoint,
    input wire logic [1:0] slvTxLevel,
    input wire logic [1:0] slvRxLevel,
    input wire logic [1:0] mstTxLevel,
    input wire logic [1:0] mstRxLevel,
    output logic slvStretching,
    output logic mstStretching
);
    typedef struct packed {
        logic awTaken;
        logic wTaken;
        logic [31:0] awAddr;
        logic [7:0] wLow;
        logic wLowEn;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [1:0] rResp;
        logic [15:0] rData;
        logic [7:0] ctl;
        logic slvFlag;
        logic mstFlag;
        logic sclPrev;
    } asc_top_t;

    asc_top_t q, d;
    logic rstSyncN;
    logic sclSync;
    logic sclFall;
    logic [3:0] slvCtl;
    logic [3:0] mstCtl;
    logic [9:0] divSum;
    logic [ASC_BASE_W-1:0] baseCount;
    logic slvHold, mstHold;
    logic slvHoldTx, mstHoldTx;
    logic slvTimeout, mstTimeout;
    logic arTake, arHit, awTake, wTake;

    // Reset asserts at once and releases on the clock
    asc_sync2 #(.RESET_VAL(1'b0)) u_rst_sync (
        .mclk(mclk),
        .rstN(rst_n),
        .d(1'b1),
        .q(rstSyncN)
    );

    // The bus line is asynchronous to this clock
    asc_sync2 #(.RESET_VAL(1'b1)) u_scl_sync (
        .mclk(mclk),
        .rstN(rstSyncN),
        .d(sclIn),
        .q(sclSync)
    );

    assign sclFall = q.sclPrev & ~sclSync;
    assign slvCtl = q.ctl[ASC_SLV_CTL_LSB +: 4];
    assign mstCtl = q.ctl[ASC_MST_CTL_LSB +: 4];

    // Base counts in divided-clock cycles, so the bus rate plays no part;
    // a base of zero would wrap to the longest timeout of the counter, so it is held at one
    assign divSum = 10'(serialClockDivisor[ASC_DIV_HI_LSB +: 8])
        + 10'(serialClockDivisor[ASC_DIV_LO_LSB +: 4]);
    assign baseCount = (divSum <= ASC_BASE_MIN) ? ASC_BASE_W'(1)
        : ASC_BASE_W'(divSum - ASC_BASE_MIN);

    // Slave role engine: FIFO empty/full thresholds of the 2-byte FIFOs
    asc_stretch_unit u_slv (
        .mclk(mclk),
        .rstSyncN(rstSyncN),
        .mode(slvCtl),
        .sclFall(sclFall),
        .txPoint(slvTxPoint),
        .rxPoint(slvRxPoint),
        .txLevel(slvTxLevel),
        .rxLevel(slvRxLevel),
        .baseCount(baseCount),
        .hold(slvHold),
        .holdTx(slvHoldTx),
        .timeout(slvTimeout)
    );

    // Master role engine, same structure as the slave one
    asc_stretch_unit u_mst (
        .mclk(mclk),
        .rstSyncN(rstSyncN),
        .mode(mstCtl),
        .sclFall(sclFall),
        .txPoint(mstTxPoint),
        .rxPoint(mstRxPoint),
        .txLevel(mstTxLevel),
        .rxLevel(mstRxLevel),
        .baseCount(baseCount),
        .hold(mstHold),
        .holdTx(mstHoldTx),
        .timeout(mstTimeout)
    );

    // Open-drain drive: only ever pulls low
    assign sclOut = 1'b0;
    assign sclOe = slvHold | mstHold;
    assign slvStretching = slvHold;
    assign mstStretching = mstHold;

    // Bus handshakes; one write and one read in flight at a time
    assign s_axi_awready = ~q.awTaken & ~q.bValid;
    assign s_axi_wready = ~q.wTaken & ~q.bValid;
    assign s_axi_arready = ~q.rValid;
    assign awTake = s_axi_awvalid & s_axi_awready;
    assign wTake = s_axi_wvalid & s_axi_wready;
    assign arTake = s_axi_arvalid & s_axi_arready;
    assign arHit = s_axi_araddr == ASC_CTRL_ADDR;

    // Register file, bus slave and sticky flags
    always_comb begin
        d = q;
        d.sclPrev = sclSync;
        if (awTake) begin
            d.awTaken = 1'b1;
            d.awAddr = s_axi_awaddr;
        end
        if (wTake) begin
            d.wTaken = 1'b1;
            d.wLow = s_axi_wdata[7:0];
            d.wLowEn = s_axi_wstrb[0];
        end
        // Address and data may come in either order
        if (q.awTaken && q.wTaken) begin
            d.awTaken = 1'b0;
            d.wTaken = 1'b0;
            d.bValid = 1'b1;
            if (q.awAddr == ASC_CTRL_ADDR) begin
                d.bResp = ASC_RESP_OKAY;
                if (q.wLowEn) begin
                    d.ctl = q.wLow;
                end
            end else begin
                d.bResp = ASC_RESP_SLVERR;
            end
        end
        if (q.bValid && s_axi_bready) begin
            d.bValid = 1'b0;
        end
        if (q.rValid && s_axi_rready) begin
            d.rValid = 1'b0;
        end
        // A read returns the flags as they stood, then clears them
        if (arTake) begin
            d.rValid = 1'b1;
            if (arHit) begin
                d.rResp = ASC_RESP_OKAY;
                d.rData = ASC_CTRL_RESET;
                d.rData[7:0] = q.ctl;
                d.rData[ASC_SLV_FLAG_BIT] = q.slvFlag;
                d.rData[ASC_MST_FLAG_BIT] = q.mstFlag;
                d.slvFlag = 1'b0;
                d.mstFlag = 1'b0;
            end else begin
                d.rResp = ASC_RESP_SLVERR;
                d.rData = '0;
            end
        end
        // Set beats the read clear so no timeout is lost
        if (slvTimeout) begin
            d.slvFlag = 1'b1;
        end
        if (mstTimeout) begin
            d.mstFlag = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            q <= '{
                awTaken: 1'b0,
                wTaken: 1'b0,
                awAddr: '0,
                wLow: '0,
                wLowEn: 1'b0,
                bValid: 1'b0,
                bResp: ASC_RESP_OKAY,
                rValid: 1'b0,
                rResp: ASC_RESP_OKAY,
                rData: '0,
                ctl: ASC_CTL_RESET,
                slvFlag: 1'b0,
                mstFlag: 1'b0,
                sclPrev: 1'b1
            };
        end else begin
            q <= d;
        end
    end

    assign s_axi_bvalid = q.bValid;
    assign s_axi_bresp = q.bResp;
    assign s_axi_rvalid = q.rValid;
    assign s_axi_rresp = q.rResp;
    assign s_axi_rdata = {16'h0000, q.rData};

    // Checks on the block's own outputs
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstSyncN);

    // Setting zero never leads to a stretch
    property p_slv_off;
        (slvCtl == ASC_MODE_OFF) [*2] |-> !slvHold;
    endproperty
    a_slv_off: assert property (p_slv_off)
        else $error("slave stretched with setting zero");

    property p_mst_off;
        (mstCtl == ASC_MODE_OFF) [*2] |-> !mstHold;
    endproperty
    a_mst_off: assert property (p_mst_off)
        else $error("master stretched with setting zero");

    // A timeout raises the flag on the next edge
    property p_slv_flag;
        slvTimeout |=> q.slvFlag;
    endproperty
    a_slv_flag: assert property (p_slv_flag)
        else $error("slave timeout flag not set");

    property p_mst_flag;
        mstTimeout |=> q.mstFlag;
    endproperty
    a_mst_flag: assert property (p_mst_flag)
        else $error("master timeout flag not set");

    // A read of the register clears a flag not set again meanwhile
    property p_slv_rdclr;
        arTake && arHit && !slvTimeout |=> !q.slvFlag;
    endproperty
    a_slv_rdclr: assert property (p_slv_rdclr)
        else $error("slave flag survived a read");

    property p_mst_rdclr;
        arTake && arHit && !mstTimeout |=> !q.mstFlag && s_axi_rvalid;
    endproperty
    a_mst_rdclr: assert property (p_mst_rdclr)
        else $error("master flag survived a read");

    // Unlimited setting never times out
    property p_slv_nolimit;
        $past(slvCtl) == ASC_MODE_NOLIMIT |-> !slvTimeout;
    endproperty
    a_slv_nolimit: assert property (p_slv_nolimit)
        else $error("slave timed out in unlimited setting");

    property p_mst_nolimit;
        $past(mstCtl) == ASC_MODE_NOLIMIT |-> !mstTimeout;
    endproperty
    a_mst_nolimit: assert property (p_mst_nolimit)
        else $error("master timed out in unlimited setting");

    // Master transmit stretch starts one edge after the falling edge
    property p_mst_tx_start;
        sclFall && mstTxPoint && mstTxLevel == ASC_FIFO_EMPTY
            && mstCtl != ASC_MODE_OFF && !mstHold |=> mstHold && sclOe;
    endproperty
    a_mst_tx_start: assert property (p_mst_tx_start)
        else $error("master transmit stretch not started");

    // Slave receive stretch starts on a full FIFO
    property p_slv_rx_start;
        sclFall && slvRxPoint && !slvTxPoint && slvRxLevel == ASC_FIFO_FULL
            && slvCtl != ASC_MODE_OFF && !slvHold |=> slvHold;
    endproperty
    a_slv_rx_start: assert property (p_slv_rx_start)
        else $error("slave receive stretch not started");

    // Data in the transmit FIFO, or room in the receive FIFO, ends the stretch on the next edge
    property p_slv_tx_release;
        slvHoldTx && slvTxLevel != ASC_FIFO_EMPTY |=> !slvHold;
    endproperty
    a_slv_tx_release: assert property (p_slv_tx_release)
        else $error("slave transmit stretch not released");

    property p_mst_rx_release;
        mstHold && !mstHoldTx && mstRxLevel != ASC_FIFO_FULL |=> !mstHold;
    endproperty
    a_mst_rx_release: assert property (p_mst_rx_release)
        else $error("master receive stretch not released");

    // A timeout only ends a stretch that was under way
    property p_mst_expire;
        mstTimeout |-> !mstHold && $past(mstHold, 1);
    endproperty
    a_mst_expire: assert property (p_mst_expire)
        else $error("master timeout without a stretch");
endmodule // asc_auto_stretch
`default_nettype wire

// >>> asc_i2c_peer.sv
`timescale 1ns/1ps
`default_nettype none
module asc_i2c_peer (
    input wire logic mclk,
    input wire logic fallReq,
    input wire logic [7:0] lowCycles,
    input wire logic sclOe,
    output logic sclLine
);
    logic [7:0] lowCnt_q = 8'h00;

    // Remote master drives one low phase of SCL, its length set per run
    always @(posedge mclk) begin
        if (fallReq) begin
            lowCnt_q <= lowCycles;
        end else if (lowCnt_q != 8'h00) begin
            lowCnt_q <= lowCnt_q - 8'h01;
        end
    end

    // Wired-AND with a pull-up: a stretch keeps the line low after the peer lets go
    assign sclLine = !((lowCnt_q != 8'h00) || sclOe);
endmodule // asc_i2c_peer
`default_nettype wire

// >>> asc_auto_stretch_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module asc_auto_stretch_tb_top
    import asc_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sclOut, sclOe, sclLine, slvStr, mstStr;
    logic [1:0] bresp, rresp;
    logic [15:0] div = 16'h0101;
    logic [3:0] point = 4'h0;
    logic [3:0] strb = 4'hf;
    logic [1:0] lvl [4] = '{2'h1, 2'h0, 2'h1, 2'h0};
    logic fallReq = 1'b0;
    // Low phase outlasts the three-edge detection delay, so a stretch extends it without a glitch
    logic [7:0] lowT = 8'h05;
    logic [7:0] seed = 8'h24;
    logic [1:0] wq [$];
    logic [33:0] rq [$];
    int numErrors = 0;
    int nChecks = 0;

    always #50 mclk = ~mclk;

    asc_auto_stretch DUT (
        .mclk(mclk),
        .rst_n(rst_n),
        .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid),
        .s_axi_awready(awready),
        .s_axi_wdata(wdata),
        .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid),
        .s_axi_wready(wready),
        .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid),
        .s_axi_bready(bready),
        .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid),
        .s_axi_arready(arready),
        .s_axi_rdata(rdata),
        .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid),
        .s_axi_rready(rready),
        .sclIn(sclLine),
        .sclOut(sclOut),
        .sclOe(sclOe),
        .serialClockDivisor(div),
        .slvTxPoint(point[0]),
        .slvRxPoint(point[1]),
        .mstTxPoint(point[2]),
        .mstRxPoint(point[3]),
        .slvTxLevel(lvl[0]),
        .slvRxLevel(lvl[1]),
        .mstTxLevel(lvl[2]),
        .mstRxLevel(lvl[3]),
        .slvStretching(slvStr),
        .mstStretching(mstStr)
    );

    asc_i2c_peer peer (
        .mclk(mclk),
        .fallReq(fallReq),
        .lowCycles(lowT),
        .sclOe(sclOe),
        .sclLine(sclLine)
    );

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        nChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic completeRun();
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One bus transfer; the handshake is judged between edges where outputs are settled
    task automatic axi(input bit wr, input logic [31:0] a, input logic [31:0] d,
            input logic [33:0] e);
        bit ta, tw, done;
        if (wr) begin
            wq.push_back(e[33:32]);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            rq.push_back(e);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        done = 1'b0;
        for (int n = 0; n < 100 && !done; n++) begin
            @(negedge mclk);
            ta = (awvalid && awready) || (arvalid && arready);
            tw = wvalid && wready;
            done = (bvalid && bready) || (rvalid && rready);
            @(posedge mclk);
            if (ta) begin
                awvalid <= 1'b0;
                arvalid <= 1'b0;
            end
            if (tw) begin
                wvalid <= 1'b0;
            end
            if (done) begin
                bready <= 1'b0;
                rready <= 1'b0;
            end
        end
        // One idle edge keeps the next call from reassigning a ready in the same step
        @(posedge mclk);
        if (!done) begin
            numErrors++;
            completeRun();
        end
    endtask

    // Responses are matched against the oldest outstanding expectation
    always @(negedge mclk) begin
        if (bvalid && bready) begin
            check(bresp, wq.pop_front());
        end
        if (rvalid && rready) begin
            check({rresp, rdata}, rq.pop_front());
        end
    end

    // idx: 0 slave tx, 1 slave rx, 2 master tx, 3 master rx; relAt 0 leaves the FIFO alone
    task automatic stretch(input int idx, input logic [3:0] mode, input logic [15:0] dv,
            input logic [1:0] lv, input int relAt, input int expLen);
        logic [31:0] cnt;
        logic on;
        logic [7:0] ctl;
        logic [1:0] fl;
        logic [1:0] idle;
        idle = (idx % 2) ? 2'h0 : 2'h1;
        ctl = (idx < 2) ? {mode, 4'h0} : {4'h0, mode};
        fl = (relAt == 0 && expLen > 0) ? ((idx < 2) ? 2'h2 : 2'h1) : 2'h0;
        div <= dv;
        axi(1, ASC_CTRL_ADDR, {24'h0, ctl}, {ASC_RESP_OKAY, 32'h0});
        lvl[idx] <= lv;
        point[idx] <= 1'b1;
        fallReq <= 1'b1;
        @(posedge mclk);
        fallReq <= 1'b0;
        cnt = 0;
        for (int n = 0; n < 20000; n++) begin
            @(negedge mclk);
            on = (idx < 2) ? slvStr : mstStr;
            if (on && cnt == 1) begin
                check({sclOut, sclOe, sclLine}, 3'h2);
            end
            cnt += on;
            if ((cnt > 0 && !on) || (cnt == 0 && n > 40)) begin
                break;
            end
            @(posedge mclk);
            if (relAt > 0 && cnt == relAt) begin
                lvl[idx] <= idle;
            end
        end
        @(posedge mclk);
        check(cnt, expLen);
        lvl[idx] <= idle;
        point[idx] <= 1'b0;
        axi(0, ASC_CTRL_ADDR, 32'h0, {ASC_RESP_OKAY, 22'h0, fl, ctl});
        if (fl != 2'h0) begin
            axi(0, ASC_CTRL_ADDR, 32'h0, {ASC_RESP_OKAY, 24'h0, ctl});
        end
    endtask

    // Main sequence: registers first, then every role and setting class
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        axi(1, ASC_CTRL_ADDR + 32'h4, 32'hff, {ASC_RESP_SLVERR, 32'h0});
        axi(0, ASC_CTRL_ADDR + 32'h4, 32'h0, {ASC_RESP_SLVERR, 32'h0});
        axi(0, ASC_CTRL_ADDR, 32'h0, {ASC_RESP_OKAY, 16'h0, ASC_CTRL_RESET});
        // Upper byte carries noise, including the read-only flag positions
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            axi(1, ASC_CTRL_ADDR, {16'h0, ~seed, seed}, {ASC_RESP_OKAY, 32'h0});
            axi(0, ASC_CTRL_ADDR, 32'h0, {ASC_RESP_OKAY, 24'h0, seed});
        end
        // Lane zero switched off: the write must leave the settings alone
        strb <= 4'he;
        axi(1, ASC_CTRL_ADDR, 32'h0, {ASC_RESP_OKAY, 32'h0});
        strb <= 4'hf;
        axi(0, ASC_CTRL_ADDR, 32'h0, {ASC_RESP_OKAY, 24'h0, seed});
        stretch(0, 4'h0, 16'h0101, 2'h0, 0, 0);
        stretch(3, 4'h0, 16'h0101, 2'h2, 0, 0);
        stretch(1, 4'hf, 16'h0101, 2'h1, 0, 0);
        stretch(2, 4'hf, 16'h0101, 2'h1, 0, 0);
        stretch(0, 4'hf, 16'h0101, 2'h0, 30, 31);
        stretch(1, 4'hf, 16'h0101, 2'h2, 12, 13);
        stretch(2, 4'hf, 16'h0101, 2'h0, 20, 21);
        stretch(3, 4'hf, 16'h0101, 2'h2, 5, 6);
        // Finite timeouts keep the bus from locking up
        stretch(0, 4'h2, 16'h0210, 2'h0, 0, 8);
        lowT <= 8'h09;
        stretch(1, 4'h3, 16'h0120, 2'h2, 0, 16);
        stretch(2, 4'h1, 16'h0301, 2'h0, 0, 4);
        stretch(2, 4'h3, 16'h0210, 2'h0, 5, 6);
        stretch(0, 4'h1, 16'h0000, 2'h0, 0, 2);
        stretch(3, 4'he, 16'h0101, 2'h2, 0, 16384);
        completeRun();
    end
endmodule // asc_auto_stretch_tb_top
`default_nettype wire
